/* hw/tcro_twi.sv */
// Two-wire serial channel with its second control register, APB slave and interrupt
`timescale 1ns/1ps
`include "tcro_regs.svh"

// How it works
// - Master flags done on acked write address, acked sent byte, or acked received byte.
// - Slave flags done when a read address matches its own address and ack enable is one.
// - Slave flags done after acknowledging a received byte.
// - Slave flags done when its sent byte is acked and ack enable is one.
// - Any software access to the shift buffer clears the done flag, except in a cycle where a done event sets it.
// - Slave holds the clock low after each byte that flags done (not after a write address) while clock hold is allowed.
// - Writing one to the begin request issues a start and enters master mode.
// - Begin request is software set or cleared and hardware clears it after the start.
// - A master halt request issues a stop after the current byte or start.
// - Halt request is software set or cleared and cleared when a stop is seen.
// - Rate code divides the system clock by 1024 halving per step to 16.
// - The rate code is ignored while acting as slave.
// - Software keeps the clock at or below 400 kHz for its system clock.
// - Master bit timing is derived from the system clock; as slave, bits follow the clock line.
// - Master flag sets when we drive a start, clears when a stop is seen.
// - Ack enable zero answers not-acknowledge, one acknowledges address or data.
module tcro_twi
	import tcro_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	output logic             irq,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe
);

	// ************************************************************
	// Declarations
	// ************************************************************
	tcro_ctrl_b_t ctrl_b_r;
	tcro_state_t  state_r;
	logic [6:0]   own_slave_addr_r;
	logic         gen_call_r;
	logic [7:0]   shift_buffer_r;
	logic         enable_r;
	logic         ack_enable_r;
	logic         master_flag_r;
	logic [3:0]   irq_stat_r;
	logic [3:0]   irq_mask_r;
	logic         pready_r;
	logic [31:0]  prdata_r;
	logic         pslverr_r;
	logic         irq_r;
	logic         scl_m_r, scl_s_r, scl_d_r;
	logic         sda_m_r, sda_s_r, sda_d_r;
	logic         busy_r;
	logic [7:0]   q_cnt_r;
	logic [1:0]   ph_r;
	logic [3:0]   cnt_r;
	logic [7:0]   sh_r;
	logic         ack_r;
	logic         m_rd_r;
	logic         m_addr_r;
	logic         s_match_r;
	logic         hold_r;
	logic         scl_oe_r;
	logic         sda_oe_r;
	logic         ev_done_r, ev_start_r, ev_nack_r, cap_r;
	logic [9:0]   idx;
	logic         acc, wr, rd, buf_wr, buf_rd;
	logic         hit;
	logic [31:0]  rd_data;
	logic         start_det, stop_det, scl_rise, scl_fall;
	logic         is_master, tick, rxm, match;
	logic [7:0]   quarter;
	logic [2:0]   state_code;

	// ************************************************************
	// APB decode
	// ************************************************************
	assign idx    = paddr[11:2];
	assign acc    = psel & penable & pready_r;
	assign wr     = acc & pwrite;
	assign rd     = acc & ~pwrite;
	assign buf_wr = wr & (idx == `TCRO_IDX_SHIFT_BUF);
	assign buf_rd = rd & (idx == `TCRO_IDX_SHIFT_BUF);

	always_comb begin
		hit     = 1'b1;
		rd_data = 32'h0000_0000;
		if (idx == `TCRO_IDX_CH0_CTRL_B) begin
			rd_data[7:0] = ctrl_b_r;
		end else if (idx == `TCRO_IDX_OWN_ADDR) begin
			rd_data[7:0] = {own_slave_addr_r, gen_call_r};
		end else if (idx == `TCRO_IDX_SHIFT_BUF) begin
			rd_data[7:0] = shift_buffer_r;
		end else if (idx == `TCRO_IDX_CTRL_A) begin
			rd_data[`TCRO_CTLA_ENABLE] = enable_r;
			rd_data[`TCRO_CTLA_MASTER] = master_flag_r;
			rd_data[`TCRO_CTLA_ACK_EN] = ack_enable_r;
			rd_data[2:0]               = state_code;
		end else if (idx == `TCRO_IDX_IRQ_STAT) begin
			rd_data[3:0] = irq_stat_r;
		end else if (idx == `TCRO_IDX_IRQ_MASK) begin
			rd_data[3:0] = irq_mask_r;
		end else begin
			hit = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= psel & penable & ~pready_r;
			prdata_r  <= (psel & penable & ~pready_r & ~pwrite) ? rd_data : 32'h0000_0000;
			pslverr_r <= psel & penable & ~pready_r & ~hit;
		end
	end

	// ************************************************************
	// Status readout
	// ************************************************************
	always_comb begin
		case (state_r)
			TCRO_ST_M_START, TCRO_ST_S_ADDR: state_code = 3'h1;
			TCRO_ST_M_XFER:  state_code = rxm ? 3'h3 : 3'h2;
			TCRO_ST_S_RX:    state_code = 3'h2;
			TCRO_ST_S_TX:    state_code = 3'h3;
			TCRO_ST_M_STOP, TCRO_ST_S_WAIT: state_code = 3'h4;
			TCRO_ST_M_HOLD:  state_code = m_rd_r ? 3'h3 : 3'h2;
			default:         state_code = 3'h0;
		endcase
	end

	// ************************************************************
	// Pin synchronisers and bus condition detection
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_m_r <= scl_i;
			scl_s_r <= scl_m_r;
			scl_d_r <= scl_s_r;
			sda_m_r <= sda_i;
			sda_s_r <= sda_m_r;
			sda_d_r <= sda_s_r;
		end
	end

	assign start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
	assign stop_det  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
	assign scl_rise  = scl_s_r & ~scl_d_r;
	assign scl_fall  = ~scl_s_r & scl_d_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_r <= 1'b0;
		end else if (start_det) begin
			busy_r <= 1'b1;
		end else if (stop_det) begin
			busy_r <= 1'b0;
		end
	end

	// ************************************************************
	// Master bit-rate divider
	// ************************************************************
	assign is_master = (state_r == TCRO_ST_M_START) | (state_r == TCRO_ST_M_HOLD) |
		(state_r == TCRO_ST_M_XFER) | (state_r == TCRO_ST_M_STOP);
	// Quarter period is the divisor over four; software keeps SCL within 400 kHz
	assign quarter = (ctrl_b_r.master_rate_select > `TCRO_RATE_MAX_CODE) ?
		`TCRO_QUARTER_SLOWEST :
		(`TCRO_QUARTER_SLOWEST >> ctrl_b_r.master_rate_select);
	assign tick = is_master & (q_cnt_r == 8'h00);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_cnt_r <= `TCRO_QUARTER_SLOWEST;
		end else if (!is_master || tick) begin
			q_cnt_r <= quarter;
		end else begin
			q_cnt_r <= q_cnt_r - 8'h01;
		end
	end

	// ************************************************************
	// Link engine
	// ************************************************************
	assign rxm   = m_rd_r & ~m_addr_r;
	assign match = ack_enable_r & ((sh_r[7:1] == own_slave_addr_r) |
		(gen_call_r & (sh_r[7:1] == 7'h00) & ~sh_r[0]));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r    <= TCRO_ST_IDLE;
			ph_r       <= 2'h0;
			cnt_r      <= 4'h0;
			sh_r       <= 8'h00;
			ack_r      <= 1'b1;
			m_rd_r     <= 1'b0;
			m_addr_r   <= 1'b0;
			s_match_r  <= 1'b0;
			hold_r     <= 1'b0;
			scl_oe_r   <= 1'b0;
			sda_oe_r   <= 1'b0;
			ev_done_r  <= 1'b0;
			ev_start_r <= 1'b0;
			ev_nack_r  <= 1'b0;
			cap_r      <= 1'b0;
		end else begin
			ev_done_r  <= 1'b0;
			ev_start_r <= 1'b0;
			ev_nack_r  <= 1'b0;
			cap_r      <= 1'b0;
			if (!enable_r) begin
				state_r  <= TCRO_ST_IDLE;
				hold_r   <= 1'b0;
				scl_oe_r <= 1'b0;
				sda_oe_r <= 1'b0;
			end else if (!is_master && stop_det) begin
				state_r  <= TCRO_ST_IDLE;
				hold_r   <= 1'b0;
				scl_oe_r <= 1'b0;
				sda_oe_r <= 1'b0;
			end else if (!is_master && start_det) begin
				state_r  <= TCRO_ST_S_ADDR;
				cnt_r    <= 4'h0;
				hold_r   <= 1'b0;
				scl_oe_r <= 1'b0;
				sda_oe_r <= 1'b0;
			end else begin
				case (state_r)
					TCRO_ST_IDLE: begin
						if (ctrl_b_r.begin_cond_request && !busy_r) begin
							state_r <= TCRO_ST_M_START;
							ph_r    <= 2'h2;
						end
					end
					TCRO_ST_M_START: begin
						if (tick) begin
							case (ph_r)
								2'h0: begin
									sda_oe_r <= 1'b0;
									ph_r     <= 2'h1;
								end
								2'h1: begin
									scl_oe_r <= 1'b0;
									ph_r     <= 2'h2;
								end
								2'h2: begin
									if (scl_s_r) begin
										sda_oe_r <= 1'b1;
										ph_r     <= 2'h3;
									end
								end
								default: begin
									scl_oe_r   <= 1'b1;
									ph_r       <= 2'h0;
									ev_start_r <= 1'b1;
									m_addr_r   <= 1'b1;
									state_r    <= TCRO_ST_M_HOLD;
								end
							endcase
						end
					end
					TCRO_ST_M_HOLD: begin
						ph_r <= 2'h0;
						if (ctrl_b_r.halt_cond_request) begin
							state_r <= TCRO_ST_M_STOP;
						end else if (ctrl_b_r.begin_cond_request && !ev_start_r) begin
							state_r <= TCRO_ST_M_START;
						end else if (buf_wr) begin
							state_r <= TCRO_ST_M_XFER;
							cnt_r   <= 4'h0;
							sh_r    <= pwdata[7:0];
							if (m_addr_r) begin
								m_rd_r <= pwdata[0];
							end
						end else if (buf_rd && rxm) begin
							state_r <= TCRO_ST_M_XFER;
							cnt_r   <= 4'h0;
							sh_r    <= 8'hff;
						end
					end
					TCRO_ST_M_XFER: begin
						if (tick) begin
							case (ph_r)
								2'h0: begin
									if (cnt_r != 4'h8) begin
										sda_oe_r <= ~rxm & ~sh_r[7];
									end else begin
										sda_oe_r <= rxm & ack_enable_r;
									end
									ph_r <= 2'h1;
								end
								2'h1: begin
									scl_oe_r <= 1'b0;
									ph_r     <= 2'h2;
								end
								2'h2: begin
									if (scl_s_r) begin
										if (cnt_r != 4'h8) begin
											sh_r <= {sh_r[6:0], sda_s_r};
										end else begin
											ack_r <= sda_s_r;
										end
										ph_r <= 2'h3;
									end
								end
								default: begin
									scl_oe_r <= 1'b1;
									ph_r     <= 2'h0;
									if (cnt_r != 4'h8) begin
										cnt_r <= cnt_r + 4'h1;
									end else begin
										cnt_r    <= 4'h0;
										sda_oe_r <= 1'b0;
										m_addr_r <= 1'b0;
										state_r  <= TCRO_ST_M_HOLD;
										if (rxm) begin
											cap_r     <= 1'b1;
											ev_done_r <= ack_enable_r;
										end else if (ack_r) begin
											ev_nack_r <= 1'b1;
										end else if (m_addr_r && m_rd_r) begin
											state_r <= TCRO_ST_M_XFER;
											sh_r    <= 8'hff;
										end else begin
											ev_done_r <= 1'b1;
										end
									end
								end
							endcase
						end
					end
					TCRO_ST_M_STOP: begin
						if (tick) begin
							case (ph_r)
								2'h0: begin
									sda_oe_r <= 1'b1;
									ph_r     <= 2'h1;
								end
								2'h1: begin
									scl_oe_r <= 1'b0;
									ph_r     <= 2'h2;
								end
								default: begin
									if (scl_s_r) begin
										sda_oe_r <= 1'b0;
										state_r  <= TCRO_ST_IDLE;
									end
								end
							endcase
						end
					end
					TCRO_ST_S_ADDR, TCRO_ST_S_RX, TCRO_ST_S_TX: begin
						if (hold_r) begin
							if (buf_wr || buf_rd) begin
								hold_r   <= 1'b0;
								scl_oe_r <= 1'b0;
								if (state_r == TCRO_ST_S_TX && buf_wr) begin
									sh_r     <= pwdata[7:0];
									sda_oe_r <= ~pwdata[7];
								end
							end
						end else if (scl_rise) begin
							if (cnt_r < 4'h8) begin
								sh_r  <= {sh_r[6:0], sda_s_r};
								cnt_r <= cnt_r + 4'h1;
							end else if (cnt_r == 4'h9) begin
								ack_r <= sda_s_r;
							end
						end else if (scl_fall) begin
							if (cnt_r == 4'h8) begin
								cnt_r     <= 4'h9;
								s_match_r <= match;
								if (state_r == TCRO_ST_S_ADDR) begin
									sda_oe_r <= match;
								end else begin
									sda_oe_r <= (state_r == TCRO_ST_S_RX) & ack_enable_r;
								end
							end else if (cnt_r == 4'h9) begin
								cnt_r    <= 4'h0;
								sda_oe_r <= 1'b0;
								if (state_r == TCRO_ST_S_ADDR) begin
									if (!s_match_r) begin
										state_r <= TCRO_ST_S_WAIT;
									end else if (sh_r[0]) begin
										state_r   <= TCRO_ST_S_TX;
										ev_done_r <= 1'b1;
										hold_r    <= ctrl_b_r.clock_hold_allow;
										scl_oe_r  <= ctrl_b_r.clock_hold_allow;
										sh_r      <= shift_buffer_r;
										sda_oe_r  <= ~shift_buffer_r[7];
									end else begin
										state_r <= TCRO_ST_S_RX;
									end
								end else if (state_r == TCRO_ST_S_RX) begin
									if (ack_enable_r) begin
										cap_r     <= 1'b1;
										ev_done_r <= 1'b1;
										hold_r    <= ctrl_b_r.clock_hold_allow;
										scl_oe_r  <= ctrl_b_r.clock_hold_allow;
									end else begin
										state_r <= TCRO_ST_S_WAIT;
									end
								end else if (!ack_r && ack_enable_r) begin
									ev_done_r <= 1'b1;
									hold_r    <= ctrl_b_r.clock_hold_allow;
									scl_oe_r  <= ctrl_b_r.clock_hold_allow;
									sh_r      <= shift_buffer_r;
									sda_oe_r  <= ~shift_buffer_r[7];
								end else begin
									ev_nack_r <= ack_r;
									state_r   <= TCRO_ST_S_WAIT;
								end
							end else if (state_r == TCRO_ST_S_TX) begin
								sda_oe_r <= ~sh_r[7];
							end
						end
					end
					default: begin
						state_r <= state_r;
					end
				endcase
			end
		end
	end

	// ************************************************************
	// Second control register
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_b_r <= `TCRO_RST_CTRL_B;
		end else begin
			if (ev_done_r) begin
				ctrl_b_r.xfer_done_flag <= 1'b1;
			end else if (buf_wr || buf_rd) begin
				ctrl_b_r.xfer_done_flag <= 1'b0;
			end
			if (wr && idx == `TCRO_IDX_CH0_CTRL_B) begin
				ctrl_b_r.clock_hold_allow   <= pwdata[6];
				ctrl_b_r.begin_cond_request <= pwdata[5];
				ctrl_b_r.halt_cond_request  <= pwdata[4];
				ctrl_b_r.master_rate_select <= pwdata[3:0];
			end else begin
				if (ev_start_r) begin
					ctrl_b_r.begin_cond_request <= 1'b0;
				end
				if (stop_det) begin
					ctrl_b_r.halt_cond_request <= 1'b0;
				end
			end
		end
	end

	// ************************************************************
	// Other control, address and buffer registers
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_r     <= 1'b0;
			ack_enable_r <= 1'b0;
			{own_slave_addr_r, gen_call_r} <= `TCRO_RST_OWN_ADDR;
		end else if (wr && idx == `TCRO_IDX_CTRL_A) begin
			enable_r     <= pwdata[`TCRO_CTLA_ENABLE];
			ack_enable_r <= pwdata[`TCRO_CTLA_ACK_EN];
		end else if (wr && idx == `TCRO_IDX_OWN_ADDR) begin
			{own_slave_addr_r, gen_call_r} <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_buffer_r <= `TCRO_RST_SHIFT_BUF;
		end else if (buf_wr) begin
			shift_buffer_r <= pwdata[7:0];
		end else if (cap_r) begin
			shift_buffer_r <= sh_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			master_flag_r <= 1'b0;
		end else if (ev_start_r) begin
			master_flag_r <= 1'b1;
		end else if (stop_det) begin
			master_flag_r <= 1'b0;
		end
	end

	// ************************************************************
	// Interrupt status, mask and output
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= 4'h0;
			irq_mask_r <= `TCRO_RST_IRQ_MASK;
			irq_r      <= 1'b0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~((wr && idx == `TCRO_IDX_IRQ_STAT) ? pwdata[3:0] : 4'h0))
				| {ev_nack_r, stop_det, ev_start_r, ev_done_r};
			if (wr && idx == `TCRO_IDX_IRQ_MASK) begin
				irq_mask_r <= pwdata[3:0];
			end
			irq_r <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end else begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end
	end

	assign pready  = pready_r;
	assign prdata  = prdata_r;
	assign pslverr = pslverr_r;
	assign irq     = irq_r;
	assign scl_oe  = scl_oe_r;
	assign sda_oe  = sda_oe_r;

endmodule

/* hw/tcro_regs.svh */
// Register indices, field positions, reset values and timing counts of the serial link
`ifndef TCRO_REGS_SVH
`define TCRO_REGS_SVH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define TCRO_IDX_CH0_CTRL_B     10'h09d
`define TCRO_IDX_CH1_CTRL_B     10'h0a5
`define TCRO_IDX_CHX_CTRL_B     10'h0c5
`define TCRO_IDX_OWN_ADDR       10'h09e
`define TCRO_IDX_SHIFT_BUF      10'h09f
`define TCRO_IDX_CTRL_A         10'h0e0
`define TCRO_IDX_IRQ_STAT       10'h0e1
`define TCRO_IDX_IRQ_MASK       10'h0e2

// ************************************************************
// Field positions
// ************************************************************
`define TCRO_CTLA_ENABLE        7
`define TCRO_CTLA_MASTER        5
`define TCRO_CTLA_ACK_EN        3
`define TCRO_IRQ_DONE           0
`define TCRO_IRQ_START          1
`define TCRO_IRQ_STOP           2
`define TCRO_IRQ_NACK           3

// ************************************************************
// Reset values
// ************************************************************
`define TCRO_RST_CTRL_B         8'h00
`define TCRO_RST_OWN_ADDR       8'h00
`define TCRO_RST_SHIFT_BUF      8'h00
`define TCRO_RST_IRQ_MASK       4'h0

// ************************************************************
// Rate and timing
// ************************************************************
`define TCRO_RATE_MAX_CODE      4'h6
`define TCRO_QUARTER_SLOWEST    8'hff
`define TCRO_SYS_CLK_KHZ        25000
`define TCRO_SCL_MAX_KHZ        400

`endif

/* hw/tcro_pkg.sv */
// Types shared by the serial link control logic
package tcro_pkg;

	// Second control register layout
	typedef struct packed {
		logic       xfer_done_flag;
		logic       clock_hold_allow;
		logic       begin_cond_request;
		logic       halt_cond_request;
		logic [3:0] master_rate_select;
	} tcro_ctrl_b_t;

	// Link engine states, Gray coded in declaration order
	typedef enum logic [3:0] {
		TCRO_ST_IDLE    = 4'h0,
		TCRO_ST_M_START = 4'h1,
		TCRO_ST_M_HOLD  = 4'h3,
		TCRO_ST_M_XFER  = 4'h2,
		TCRO_ST_M_STOP  = 4'h6,
		TCRO_ST_S_ADDR  = 4'h7,
		TCRO_ST_S_RX    = 4'h5,
		TCRO_ST_S_TX    = 4'h4,
		TCRO_ST_S_WAIT  = 4'hc
	} tcro_state_t;

endpackage

/* testbench/tcro_twi_props.sv */
// Port checks for the serial link channel
`timescale 1ns/1ps
`include "tcro_regs.svh"
module tcro_twi_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        irq,
	input wire logic        scl_i,
	input wire logic        scl_o,
	input wire logic        scl_oe,
	input wire logic        sda_i,
	input wire logic        sda_o,
	input wire logic        sda_oe
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Data line pulled low or released while the clock line is free
	sequence start_seen;
		$rose(sda_oe) && scl_i;
	endsequence
	sequence stop_seen;
		$fell(sda_oe) && scl_i;
	endsequence
	ready_after_a: assert property (psel && $rose(penable) |=> pready)
		else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready too long");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not idle");
	rdata_width_a: assert property (prdata[31:8] == 24'h0)
		else $error("prdata upper bits set");
	unmapped_err_a: assert property (pready && (paddr[11:2] == `TCRO_IDX_CH1_CTRL_B
		|| paddr[11:2] == `TCRO_IDX_CHX_CTRL_B) |-> pslverr)
		else $error("unmapped access accepted");
	mapped_ok_a: assert property (pready && paddr[11:2] == `TCRO_IDX_CH0_CTRL_B |-> !pslverr)
		else $error("mapped access refused");
	start_clock_a: assert property (start_seen |-> ##[1:300] scl_oe)
		else $error("no clock after start");
	stop_idle_a: assert property (stop_seen |=> !scl_oe [*3])
		else $error("clock pulled after stop");
	open_drain_a: assert property (!scl_o && !sda_o)
		else $error("line driven high");
endmodule

/* testbench/tcro_slave_model.sv */
// Behavioural two-wire slave that acknowledges writes to its address
`timescale 1ns/1ps
module tcro_slave_model #(
	parameter logic [6:0] OWN_ADDR = 7'h50
) (
	input  wire logic  scl,
	input  wire logic  sda,
	output logic       sda_pull,
	output logic [7:0] last_byte
);
	logic [7:0] shreg;
	logic [3:0] bitc;
	logic       first;
	logic       sel;
	initial begin
		sda_pull = 1'b0;
		last_byte = 8'h00;
		shreg = 8'h00;
		bitc = 4'h0;
		first = 1'b0;
		sel = 1'b0;
	end
	// Start or stop: data line moves while the clock line is high
	always @(sda) begin
		if (scl === 1'b1) begin
			bitc = 4'h0;
			first = !sda;
			sel = sel && !sda;
		end
	end
	always @(posedge scl) begin
		shreg = {shreg[6:0], sda};
		bitc = bitc + 4'h1;
	end
	// Acknowledge in the ninth bit, release after it
	always @(negedge scl) begin
		if (bitc == 4'h8) begin
			if (first)
				sel = shreg[7:1] == OWN_ADDR && !shreg[0];
			if (!first && sel)
				last_byte = shreg;
			sda_pull = sel;
			first = 1'b0;
		end else if (bitc == 4'h9) begin
			sda_pull = 1'b0;
			bitc = 4'h0;
		end
	end
endmodule

/* testbench/tcro_twi_tb.sv */
// Self-checking bench of the serial link channel
`timescale 1ns/1ps
`include "tcro_regs.svh"
module tcro_twi_tb;
	localparam logic [9:0] idx_cb = `TCRO_IDX_CH0_CTRL_B;
	localparam logic [9:0] idx_ca = `TCRO_IDX_CTRL_A;
	localparam logic [9:0] idx_sb = `TCRO_IDX_SHIFT_BUF;
	localparam logic [9:0] idx_st = `TCRO_IDX_IRQ_STAT;
	localparam logic [9:0] idx_mk = `TCRO_IDX_IRQ_MASK;
	logic        pclk, presetn, psel, penable, pwrite;
	logic        pready, pslverr, irq, scl_o, scl_oe, sda_o, sda_oe;
	logic        sda_pull, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0]  rdat, sl_byte;
	int          errors, tests_run, waited;
	wire         scl = !scl_oe;
	wire         sda = !(sda_oe || sda_pull);
	tcro_twi i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .irq(irq), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
	tcro_slave_model i_slave (.scl(scl), .sda(sda), .sda_pull(sda_pull), .last_byte(sl_byte));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// ****
	// Shared tasks
	// ****
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("Checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (pready !== 1'b1) begin
			errors++;
			report_and_stop();
		end
		rdat = prdata[7:0];
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 4000) begin
			@(negedge pclk);
			n++;
		end
		waited = n;
		if (n == 4000) begin
			errors++;
			report_and_stop();
		end
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_regs;
		apb(0, idx_cb, 8'h00);
		check("ctrl_b reset", rdat, `TCRO_RST_CTRL_B);
		check("irq reset", {7'h0, irq}, 8'h00);
		apb(1, idx_cb, 8'hd6);
		apb(0, idx_cb, 8'h00);
		check("ctrl_b set", rdat, 8'h56);
		apb(1, idx_cb, 8'h00);
		apb(0, idx_cb, 8'h00);
		check("ctrl_b clear", rdat, 8'h00);
		apb(0, `TCRO_IDX_CH1_CTRL_B, 8'h00);
		check("unmapped err", {7'h0, rerr}, 8'h01);
		check("unmapped data", rdat, 8'h00);
		$display("register test done");
	endtask
	task automatic t_master;
		int  i, first, per;
		logic p;
		apb(1, idx_ca, 8'h88);
		apb(1, idx_mk, 8'h0f);
		apb(1, idx_cb, 8'h24);
		wait_irq();
		apb(0, idx_st, 8'h00);
		check("start event", rdat & 8'h02, 8'h02);
		apb(0, idx_ca, 8'h00);
		check("master flag set", rdat & 8'h20, 8'h20);
		apb(0, idx_cb, 8'h00);
		check("begin cleared", rdat, 8'h04);
		apb(1, idx_mk, 8'h00);
		repeat (2) @(negedge pclk);
		check("irq masked", {7'h0, irq}, 8'h00);
		apb(1, idx_mk, 8'h0f);
		repeat (2) @(negedge pclk);
		check("irq unmasked", {7'h0, irq}, 8'h01);
		apb(1, idx_st, 8'h0f);
		repeat (2) @(negedge pclk);
		check("irq cleared", {7'h0, irq}, 8'h00);
		apb(1, idx_sb, 8'ha0);
		wait_irq();
		apb(0, idx_cb, 8'h00);
		check("done on addr ack", rdat, 8'h84);
		apb(1, idx_st, 8'h0f);
		apb(1, idx_sb, 8'h3c);
		apb(0, idx_cb, 8'h00);
		check("done cleared", rdat, 8'h04);
		p = scl_oe;
		first = -1;
		per = 0;
		for (i = 0; i < 200 && per == 0; i++) begin
			@(negedge pclk);
			if (scl_oe && !p) begin
				if (first >= 0)
					per = i - first;
				first = i;
			end
			p = scl_oe;
		end
		check("scl period", per[7:0], 8'h40);
		wait_irq();
		check("slave byte", sl_byte, 8'h3c);
		apb(1, idx_st, 8'h0f);
		apb(1, idx_cb, 8'h1f);
		wait_irq();
		check("slow stop", {7'h0, waited > 400}, 8'h01);
		apb(0, idx_ca, 8'h00);
		check("master flag clear", rdat & 8'h20, 8'h00);
		apb(0, idx_cb, 8'h00);
		check("halt cleared", rdat, 8'h8f);
		$display("master test done");
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		errors = 0;
		tests_run = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_master();
		report_and_stop();
	end
endmodule
bind tcro_twi tcro_twi_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .irq(irq), .scl_i(scl_i), .scl_o(scl_o),
	.scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
